// file: core/parallel_port.v
// parallel port control and master transfer engine with an AXI4-Lite register slave
// assumes one clock i_ref_clk; pin inputs arrive asynchronously; slave protocols live elsewhere
`timescale 1ns/1ps
`include "port_regs.vh"
module parallel_port #(
  parameter CLKS_PER_TCY = 4
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire [13:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [13:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  input wire [7:0] i_port_data_pins,
  output reg [7:0] o_port_data_pins,
  output reg o_port_data_oe,
  output reg [15:0] o_port_addr_pins,
  output reg o_port_addr_oe,
  output reg o_read_strobe,
  output reg o_read_strobe_oe,
  output reg o_write_strobe,
  output reg o_write_strobe_oe,
  output reg o_byte_enable_out,
  output reg o_byte_enable_oe,
  output reg o_cycle_done,
  output reg o_cpu_stall
);
  // ----------------------------------------------------------------
  // states and helpers
  // ----------------------------------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_ADDRL = 3'd1;
  localparam S_ADDRH = 3'd2;
  localparam S_SETUP = 3'd3;
  localparam S_STROBE = 3'd4;
  localparam S_HOLD = 3'd5;

  // phase length in Tcy turned into a terminal clock count
  function [9:0] tcy_clks;
    input [4:0] tcy;
    reg [31:0] prod;
    begin
      prod = tcy * CLKS_PER_TCY;
      tcy_clks = prod[9:0] - 10'd1;
    end
  endfunction

  function [11:0] word_idx;
    input [13:0] a;
    begin
      word_idx = a[13:2];
    end
  endfunction

  reg [7:0] wait_r;
  reg [7:0] mode_r;
  reg [7:0] pol_r;
  reg [7:0] en_r;
  reg [15:0] addr_r;
  reg [15:0] data_r;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [9:0] cnt_r;
  reg [9:0] cnt_nxt;
  reg byte_r;
  reg rd_r;
  reg [7:0] din_meta_r;
  reg [7:0] din_sync_r;
  reg [13:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg aw_ok_r;
  reg w_ok_r;

  wire [1:0] mux = en_r[`EN_MUX_HI:`EN_MUX_LO];
  wire [1:0] chip_select_function = pol_r[`POL_CSF_HI:`POL_CSF_LO];
  wire [1:0] interrupt_mode = mode_r[`MODE_IRQ_HI:`MODE_IRQ_LO];
  wire [1:0] increment_mode = mode_r[`MODE_INC_HI:`MODE_INC_LO];
  wire [1:0] msel = mode_r[`MODE_SEL_HI:`MODE_SEL_LO];
  wire [3:0] st_wait = wait_r[`WAIT_ST_HI:`WAIT_ST_LO];
  wire sw0 = (st_wait == `ST_ZERO);
  wire master = (msel == `MODE_M1) || (msel == `MODE_M2);
  wire port_on = en_r[`EN_PORT_ON];
  wire busy = (st_r != S_IDLE);
  // su_tcy collapses to one Tcy when the strobe wait is zero, shortening only the address phases; setup is then skipped, hold keeps its length but is skipped too
  wire [4:0] su_tcy = sw0 ? 5'd1 : {3'd0, wait_r[`WAIT_SU_HI:`WAIT_SU_LO]} + 5'd1;
  wire [4:0] hd_tcy = {3'd0, wait_r[`WAIT_HD_HI:`WAIT_HD_LO]} + 5'd1;
  wire [4:0] sb_tcy = {1'b0, st_wait} + 5'd1;
  wire [2:0] first_st = (mux == `MUX_SEP) ? (sw0 ? S_STROBE : S_SETUP) : S_ADDRL;
  wire last_clk = (cnt_r == 10'd0);
  wire wr_go = aw_ok_r && w_ok_r && !o_s_axi_bvalid;
  wire [11:0] widx = word_idx(awaddr_r);
  wire launch_ok = port_on && master && !busy;
  wire [14:0] step_vec = {addr_r[15], addr_r[13:0]};
  wire [14:0] step_up = step_vec + 15'd1;
  wire [14:0] step_dn = step_vec - 15'd1;

  function [9:0] len_of;
    input [2:0] s;
    begin
      case (s)
        S_ADDRL: len_of = tcy_clks(su_tcy);
        S_ADDRH: len_of = tcy_clks(su_tcy);
        S_SETUP: len_of = tcy_clks(su_tcy);
        S_STROBE: len_of = tcy_clks(sb_tcy);
        S_HOLD: len_of = tcy_clks(hd_tcy);
        default: len_of = 10'd0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // phase sequencing
  // ----------------------------------------------------------------
  always @* begin
    st_nxt = st_r;
    cnt_nxt = last_clk ? 10'd0 : cnt_r - 10'd1;
    if (busy && last_clk) begin
      case (st_r)
        S_ADDRL: st_nxt = (mux == `MUX_FULL) ? S_ADDRH : (sw0 ? S_STROBE : S_SETUP);
        S_ADDRH: st_nxt = sw0 ? S_STROBE : S_SETUP;
        S_SETUP: st_nxt = S_STROBE;
        S_STROBE: st_nxt = sw0 ? ((mode_r[`MODE_WIDE] && !byte_r) ? first_st : S_IDLE)
                               : S_HOLD;
        S_HOLD: st_nxt = (mode_r[`MODE_WIDE] && !byte_r) ? first_st : S_IDLE;
        default: st_nxt = S_IDLE;
      endcase
      cnt_nxt = len_of(st_nxt);
    end
  end

  // ----------------------------------------------------------------
  // registers and transfer engine
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_r <= `RST_BYTE;
      mode_r <= `RST_BYTE;
      pol_r <= `RST_BYTE;
      en_r <= `RST_BYTE;
      addr_r <= `RST_WORD;
      data_r <= `RST_WORD;
      st_r <= S_IDLE;
      cnt_r <= 10'd0;
      byte_r <= 1'b0;
      rd_r <= 1'b0;
      o_cycle_done <= 1'b0;
      o_cpu_stall <= 1'b0;
    end else begin
      o_cycle_done <= 1'b0;
      if (wr_go && wstrb_r[0]) begin
        case (widx)
          `IDX_WAIT: wait_r <= wdata_r[7:0];
          `IDX_MODE: mode_r <= wdata_r[7:0] & `MODE_WMASK;
          `IDX_POL: pol_r <= wdata_r[7:0] & `POL_WMASK;
          `IDX_EN: en_r <= wdata_r[7:0] & `EN_WMASK;
          default: ;
        endcase
      end
      if (!port_on || !master) begin
        // switching off aborts any transfer under way
        st_r <= S_IDLE;
        cnt_r <= 10'd0;
      end else if (wr_go && launch_ok && (widx == `IDX_DATA || widx == `IDX_RDGO)) begin
        st_r <= first_st;
        // pins start one clock after launch, so the first phase gets one more
        cnt_r <= len_of(first_st) + 10'd1;
        byte_r <= 1'b0;
        rd_r <= (widx == `IDX_RDGO);
      end else begin
        st_r <= st_nxt;
        cnt_r <= cnt_nxt;
        if (st_r == S_STROBE && last_clk && rd_r) begin
          if (byte_r)
            data_r[15:8] <= din_sync_r;
          else
            data_r[7:0] <= din_sync_r;
        end
        if (busy && last_clk && st_nxt == first_st && st_r != S_IDLE)
          byte_r <= 1'b1;
        if (busy && last_clk && st_nxt == S_IDLE) begin
          o_cycle_done <= (interrupt_mode == `IRQ_END);
          if (increment_mode == `INC_UP) begin
            addr_r[15] <= step_up[14];
            addr_r[13:0] <= step_up[13:0];
          end else if (increment_mode == `INC_DN) begin
            addr_r[15] <= step_dn[14];
            addr_r[13:0] <= step_dn[13:0];
          end
        end
      end
      // address and data registers refuse writes while busy
      if (wr_go && !busy && widx == `IDX_ADDR) begin
        if (wstrb_r[0]) addr_r[7:0] <= wdata_r[7:0];
        if (wstrb_r[1]) addr_r[15:8] <= wdata_r[15:8];
      end
      if (wr_go && !busy && widx == `IDX_DATA) begin
        if (wstrb_r[0]) data_r[7:0] <= wdata_r[7:0];
        if (wstrb_r[1]) data_r[15:8] <= wdata_r[15:8];
      end
      o_cpu_stall <= (interrupt_mode == `IRQ_STALL) && (st_nxt != S_IDLE) && port_on && master;
    end
  end

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      din_meta_r <= 8'h00;
      din_sync_r <= 8'h00;
    end else begin
      din_meta_r <= i_port_data_pins;
      din_sync_r <= din_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (word_idx(i_s_axi_araddr))
      `IDX_WAIT: rd_mux[7:0] = wait_r;
      `IDX_MODE: rd_mux[7:0] = {busy, mode_r[6:0]};
      `IDX_POL: rd_mux[7:0] = pol_r;
      `IDX_EN: rd_mux[7:0] = en_r;
      `IDX_ADDR: rd_mux[15:0] = addr_r;
      `IDX_DATA: rd_mux[15:0] = data_r;
      `IDX_RDGO: rd_mux = 32'h00000000;
      default: rd_hit = 1'b0;
    endcase
  end

  function wmap;
    input [11:0] i;
    begin
      wmap = (i == `IDX_WAIT) || (i == `IDX_MODE) || (i == `IDX_POL) || (i == `IDX_EN) ||
             (i == `IDX_ADDR) || (i == `IDX_DATA) || (i == `IDX_RDGO);
    end
  endfunction

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `RESP_OKAY;
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= `RESP_OKAY;
      awaddr_r <= 14'h0000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        awaddr_r <= i_s_axi_awaddr;
        aw_ok_r <= 1'b1;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        wdata_r <= i_s_axi_wdata;
        wstrb_r <= i_s_axi_wstrb;
        w_ok_r <= 1'b1;
        o_s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wmap(widx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
      end
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= rd_mux;
        o_s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive, registered from next-state values
  // ----------------------------------------------------------------
  reg [15:0] a_nxt;
  reg [7:0] d_nxt;
  reg doe_nxt;
  reg rd_act;
  reg wr_act;
  wire nbusy = (st_nxt != S_IDLE) && port_on && master;
  wire n_strobe = (st_nxt == S_STROBE);
  wire n_addr = (st_nxt == S_ADDRL) || (st_nxt == S_ADDRH);
  wire n_byte = byte_r || (busy && last_clk && st_nxt == first_st);
  always @* begin
    a_nxt = addr_r;
    if (mux == `MUX_SEP)
      a_nxt[15:8] = 8'h00;
    else if (mux == `MUX_LOW)
      a_nxt[7:0] = 8'h00;
    else
      a_nxt = 16'h0000;
    if (chip_select_function == `CSF_ON) begin
      a_nxt[15:13] = 3'h0;
      a_nxt[15] = (nbusy && addr_r[`CS_ADDR_BIT]) ? pol_r[`POL_CSP] : ~pol_r[`POL_CSP];
    end
    if (mux != `MUX_SEP) begin
      a_nxt[0] = (st_nxt == S_ADDRL) ? pol_r[`POL_ALP] : ~pol_r[`POL_ALP];
      a_nxt[1] = (st_nxt == S_ADDRH) ? pol_r[`POL_ALP] : ~pol_r[`POL_ALP];
    end
    d_nxt = n_byte ? data_r[15:8] : data_r[7:0];
    if (st_nxt == S_ADDRL)
      d_nxt = addr_r[7:0];
    if (st_nxt == S_ADDRH)
      d_nxt = addr_r[15:8];
    doe_nxt = nbusy && (n_addr || !rd_r);
    if (msel == `MODE_M1) begin
      rd_act = nbusy && rd_r;
      wr_act = nbusy && n_strobe;
    end else begin
      rd_act = nbusy && n_strobe && rd_r;
      wr_act = nbusy && n_strobe && !rd_r;
    end
  end

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port_data_pins <= 8'h00;
      o_port_data_oe <= 1'b0;
      o_port_addr_pins <= 16'h0000;
      o_port_addr_oe <= 1'b0;
      o_read_strobe <= 1'b1;
      o_read_strobe_oe <= 1'b0;
      o_write_strobe <= 1'b1;
      o_write_strobe_oe <= 1'b0;
      o_byte_enable_out <= 1'b1;
      o_byte_enable_oe <= 1'b0;
    end else begin
      o_port_data_pins <= d_nxt;
      o_port_data_oe <= doe_nxt;
      o_port_addr_pins <= a_nxt;
      o_port_addr_oe <= port_on && master;
      o_read_strobe <= rd_act ? pol_r[`POL_RDP] : ~pol_r[`POL_RDP];
      o_write_strobe <= wr_act ? pol_r[`POL_WRP] : ~pol_r[`POL_WRP];
      o_byte_enable_out <= (nbusy && mode_r[`MODE_WIDE]) ? pol_r[`POL_BEP] : ~pol_r[`POL_BEP];
      // slave modes leave the strobe pins to the outside master
      o_read_strobe_oe <= port_on && master && en_r[`EN_RD_PIN];
      o_write_strobe_oe <= port_on && master && en_r[`EN_WR_PIN];
      o_byte_enable_oe <= port_on && master && en_r[`EN_BE_PIN];
    end
  end
endmodule // parallel_port

// file: core/port_regs.vh
// register indices, field positions, codes and reset values of the parallel port
// assumes it is included by the port core and the bench; definitions only
`ifndef PORT_REGS_VH
`define PORT_REGS_VH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_WAIT 12'hF5C
`define IDX_MODE 12'hF5D
`define IDX_POL 12'hF5E
`define IDX_EN 12'hF5F
`define IDX_ADDR 12'hF60
`define IDX_DATA 12'hF61
`define IDX_RDGO 12'hF62
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EN_PORT_ON 7
`define EN_MUX_HI 4
`define EN_MUX_LO 3
`define EN_BE_PIN 2
`define EN_WR_PIN 1
`define EN_RD_PIN 0
`define POL_CSF_HI 7
`define POL_CSF_LO 6
`define POL_ALP 5
`define POL_CSP 3
`define POL_BEP 2
`define POL_WRP 1
`define POL_RDP 0
`define MODE_BUSY 7
`define MODE_IRQ_HI 6
`define MODE_IRQ_LO 5
`define MODE_INC_HI 4
`define MODE_INC_LO 3
`define MODE_WIDE 2
`define MODE_SEL_HI 1
`define MODE_SEL_LO 0
`define WAIT_SU_HI 7
`define WAIT_SU_LO 6
`define WAIT_ST_HI 5
`define WAIT_ST_LO 2
`define WAIT_HD_HI 1
`define WAIT_HD_LO 0
`define CS_ADDR_BIT 14
// ----------------------------------------------------------------
// writable masks and codes
// ----------------------------------------------------------------
`define EN_WMASK 8'h9F
`define POL_WMASK 8'hEF
`define MODE_WMASK 8'h7F
`define MUX_SEP 2'h0
`define MUX_LOW 2'h1
`define MUX_FULL 2'h2
`define CSF_ON 2'h2
`define IRQ_END 2'h1
`define IRQ_STALL 2'h2
`define INC_UP 2'h1
`define INC_DN 2'h2
`define MODE_M1 2'h3
`define MODE_M2 2'h2
`define ST_ZERO 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: verification/ext_mem_model.sv
// byte memory standing on the far side of the port
// assumes active-low strobes; the bench pulls released lines high
`timescale 1ns/1ps
module ext_mem_model (
  input wire i_clk,
  input wire [15:0] i_addr,
  input wire [7:0] i_data,
  input wire i_rd_n,
  input wire i_wr_n,
  output logic [7:0] o_data
);
  logic [7:0] mem [0:255];
  initial begin
    o_data = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i] = ~i[7:0];
    end
  end
  // captures on every strobe cycle, so a write with no hold phase lands too
  always @(posedge i_clk) begin
    if (!i_wr_n) begin
      mem[i_addr[7:0]] <= i_data;
    end
    // toggles outside a read so stale data never looks valid
    if (!i_rd_n) begin
      o_data <= mem[i_addr[7:0]];
    end else begin
      o_data <= ~o_data;
    end
  end
endmodule // ext_mem_model

// file: verification/parallel_port_sva.sv
// pin and register bus checks of the parallel port
// assumes it is bound to parallel_port and sees only its ports
`timescale 1ns/1ps
module parallel_port_sva (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_s_axi_awvalid,
  input wire o_s_axi_awready,
  input wire i_s_axi_wvalid,
  input wire o_s_axi_wready,
  input wire o_s_axi_bvalid,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire o_s_axi_rvalid,
  input wire o_port_data_oe,
  input wire o_port_addr_oe,
  input wire o_read_strobe_oe,
  input wire o_write_strobe_oe,
  input wire o_byte_enable_oe,
  input wire o_cycle_done,
  input wire o_cpu_stall
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  // ----
  // bus and pin properties
  // ----
  sequence wr_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence b_answer;
    !o_s_axi_bvalid ##1 o_s_axi_bvalid;
  endsequence
  wr_resp_a: assert property (wr_taken |=> b_answer)
    else $error("write response not two cycles after take");
  b_busy_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write channels ready while response pending");
  rd_resp_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read data not one cycle after take");
  port_off_a: assert property (!o_port_addr_oe |->
    !o_port_data_oe && !o_write_strobe_oe && !o_read_strobe_oe)
    else $error("pins driven with port off");
  done_pulse_a: assert property (o_cycle_done |=> !o_cycle_done)
    else $error("end pulse longer than one cycle");
  done_master_a: assert property (o_cycle_done |-> o_port_addr_oe)
    else $error("end pulse outside master operation");
  stall_master_a: assert property (o_cpu_stall |-> o_port_addr_oe)
    else $error("stall outside master operation");
  be_master_a: assert property (o_byte_enable_oe |-> o_port_addr_oe)
    else $error("byte enable driven with port off");
endmodule // parallel_port_sva
bind parallel_port parallel_port_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
  .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid),
  .o_port_data_oe(o_port_data_oe), .o_port_addr_oe(o_port_addr_oe),
  .o_read_strobe_oe(o_read_strobe_oe), .o_write_strobe_oe(o_write_strobe_oe),
  .o_byte_enable_oe(o_byte_enable_oe), .o_cycle_done(o_cycle_done),
  .o_cpu_stall(o_cpu_stall));

// file: verification/parallel_port_tb.sv
// self-checking bench: registers, master writes and reads
// assumes port_regs.vh on the include path and the memory model beside
`timescale 1ns/1ps
`include "port_regs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  $display("MISMATCH %s exp %h got %h", n, e, g); fail_count++; end end
module parallel_port_tb;
  localparam int T = 4;
  logic i_ref_clk = 0, i_rst = 1, awvalid = 0, wvalid = 0, arvalid = 0;
  logic [13:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd, rdata;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid;
  wire [7:0] dq, dout, mdat;
  wire [15:0] addr;
  wire doe, aoe, rs, rsoe, ws, wsoe, be, beoe, done, stall;
  integer fail_count = 0, cmp_count = 0, doe_n = 0, wst_n = 0, rst_n = 0, done_n = 0;
  integer stall_n = 0, lat_n = 0, cs_n = 0, be_n = 0;
  // shared data line: port drives while enabled, memory otherwise
  assign dq = doe ? dout : mdat;
  parallel_port #(.CLKS_PER_TCY(T)) DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(1'b1), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(1'b1), .i_port_data_pins(dq),
    .o_port_data_pins(dout), .o_port_data_oe(doe), .o_port_addr_pins(addr),
    .o_port_addr_oe(aoe), .o_read_strobe(rs), .o_read_strobe_oe(rsoe),
    .o_write_strobe(ws), .o_write_strobe_oe(wsoe), .o_byte_enable_out(be),
    .o_byte_enable_oe(beoe), .o_cycle_done(done), .o_cpu_stall(stall));
  ext_mem_model u_mem (.i_clk(i_ref_clk), .i_addr(addr), .i_data(dq),
    .i_rd_n(rsoe ? rs : 1'b1), .i_wr_n(wsoe ? ws : 1'b1), .o_data(mdat));
  initial begin
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    doe_n <= doe_n + doe;
    wst_n <= wst_n + (wsoe && !ws);
    rst_n <= rst_n + (rsoe && !rs);
    done_n <= done_n + done;
    stall_n <= stall_n + stall;
    lat_n <= lat_n + (aoe && !addr[0]) + (aoe && !addr[1]);
    cs_n <= cs_n + (aoe && !addr[15]);
    be_n <= be_n + (beoe && !be);
  end
  // ----
  // bus tasks
  // ----
  // cleared away from the counting edge so no update is lost
  task automatic clr;
    @(negedge i_ref_clk);
    {doe_n, wst_n, rst_n, done_n, stall_n, lat_n, cs_n, be_n} = '0;
    @(posedge i_ref_clk);
  endtask
  task automatic axi_wr(input logic [11:0] idx, input logic [31:0] d);
    logic a, w;
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    a = 1;
    w = 1;
    while (a || w) begin
      @(posedge i_ref_clk);
      if (a && awready) begin
        a = 0;
        awvalid <= 0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 0;
      end
    end
    do @(posedge i_ref_clk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask
  task automatic axi_rd(input logic [11:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    do @(posedge i_ref_clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge i_ref_clk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      axi_rd(`IDX_MODE);
      n++;
    end while (rd[7] === 1'b1 && n < 200);
    `CHK("idle", 1'b0, rd[7])
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    logic [11:0] idx [4] = '{`IDX_WAIT, `IDX_MODE, `IDX_POL, `IDX_EN};
    logic [7:0] msk [4] = '{8'hFF, `MODE_WMASK, `POL_WMASK, `EN_WMASK};
    for (int i = 0; i < 4; i++) begin
      axi_rd(idx[i]);
      `CHK("reset value", 32'h0, rd)
      axi_wr(idx[i], 32'hFF);
      axi_rd(idx[i]);
      `CHK("writable bits", {24'h0, msk[i]}, rd)
      axi_wr(idx[i], 32'h0);
    end
    axi_rd(12'hF63);
    `CHK("unmapped rresp", `RESP_SLVERR, resp)
    axi_wr(12'hF63, 32'h1);
    `CHK("unmapped bresp", `RESP_SLVERR, resp)
    $display("test regs done");
  endtask
  task automatic t_xfer;
    axi_wr(`IDX_WAIT, 32'h04);
    axi_wr(`IDX_MODE, 32'h2A);
    axi_wr(`IDX_EN, 32'h87);
    axi_wr(`IDX_ADDR, 32'h12);
    clr;
    axi_wr(`IDX_DATA, 32'hA5);
    axi_rd(`IDX_MODE);
    `CHK("busy", 1'b1, rd[7])
    wait_idle;
    `CHK("write strobe", 2 * T, wst_n)
    `CHK("data drive", 4 * T, doe_n)
    `CHK("end pulse", 1, done_n)
    `CHK("mem write", 8'hA5, u_mem.mem[8'h12])
    axi_rd(`IDX_ADDR);
    `CHK("address step", 32'h13, rd)
    clr;
    axi_wr(`IDX_RDGO, 32'h0);
    wait_idle;
    axi_rd(`IDX_DATA);
    `CHK("read data", 8'hEC, rd[7:0])
    `CHK("read strobe", 2 * T, rst_n)
    `CHK("no drive", 0, doe_n)
    axi_wr(`IDX_WAIT, 32'hC3);
    clr;
    axi_wr(`IDX_DATA, 32'h5A);
    wait_idle;
    `CHK("short drive", T, doe_n)
    `CHK("short strobe", T, wst_n)
    `CHK("short write", 8'h5A, u_mem.mem[8'h14])
    $display("test transfers done");
  endtask
  task automatic t_wide;
    axi_wr(`IDX_WAIT, 32'h04);
    axi_wr(`IDX_MODE, 32'h4E);
    clr;
    axi_wr(`IDX_DATA, 32'hBEEF);
    wait_idle;
    `CHK("two strobes", 4 * T, wst_n)
    `CHK("high byte last", 8'hBE, u_mem.mem[8'h15])
    `CHK("no pulse", 0, done_n)
    `CHK("stall span", 8 * T, stall_n)
    `CHK("byte enable", 8 * T, be_n)
    $display("test wide done");
  endtask
  task automatic t_pins;
    axi_wr(`IDX_MODE, 32'h02);
    axi_wr(`IDX_EN, 32'h85);
    clr;
    axi_wr(`IDX_DATA, 32'h22);
    wait_idle;
    `CHK("strobe pin off", 1'b0, wsoe)
    `CHK("no capture", 8'hE9, u_mem.mem[8'h16])
    axi_wr(`IDX_EN, 32'h07);
    clr;
    axi_wr(`IDX_DATA, 32'h11);
    repeat (6 * T) @(posedge i_ref_clk);
    axi_rd(`IDX_MODE);
    `CHK("off busy", 1'b0, rd[7])
    `CHK("off drive", 0, doe_n + wst_n)
    axi_wr(`IDX_EN, 32'h87);
    axi_wr(`IDX_POL, 32'h03);
    repeat (2) @(posedge i_ref_clk);
    `CHK("write idle", 1'b0, ws)
    `CHK("read idle", 1'b0, rs)
    $display("test pins done");
  endtask
  task automatic t_mux;
    axi_wr(`IDX_POL, 32'h80);
    axi_wr(`IDX_MODE, 32'h13);
    axi_wr(`IDX_EN, 32'h97);
    axi_wr(`IDX_ADDR, 32'h4016);
    clr;
    axi_wr(`IDX_DATA, 32'h33);
    wait_idle;
    `CHK("latch strobes", 2 * T, lat_n)
    `CHK("chip select", 6 * T, cs_n)
    `CHK("enable strobe", 2 * T, wst_n)
    `CHK("direction idle", 0, rst_n)
    `CHK("mux drive", 6 * T, doe_n)
    axi_rd(`IDX_ADDR);
    `CHK("address down", 32'h4015, rd)
    $display("test mux done");
  endtask
  initial begin
    #400000;
    fail_count++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 0;
    t_regs;
    t_xfer;
    t_wide;
    t_pins;
    t_mux;
    wrap_up;
  end
endmodule // parallel_port_tb
